// File: verilog/bias_regs_pkg.sv
// Purpose: Shared constants and types of the bias supply register block.
// Assumes: Registers are eight bits wide and reached by an 8-bit index.
// Notes: Offsets are the serial register indices, not byte addresses.
package bias_regs_pkg;

    // ==================================================================
    // Register indices
    localparam logic [7:0] APPLICATION_CONFIG_ADDR = 8'h03;
    localparam logic [7:0] CTRL_ADDR = 8'h04;
    localparam logic [7:0] KEY_ADDR = 8'h21;

    // ==================================================================
    // Fields, key and reset values
    localparam int LIMIT_BIT = 4;
    localparam logic LIMIT_RST = 1'b0;
    localparam logic UNLOCK_RST = 1'b0;
    localparam logic [7:0] UNLOCK_KEY = 8'h4C;
    localparam logic [7:0] KEY_RD_OPEN = 8'h01;
    localparam logic [7:0] KEY_RD_SHUT = 8'h00;
    localparam logic [7:0] APPLICATION_CONFIG_LOCK_MASK = 8'h1C;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ==================================================================
    // Types
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_MASTER_ACK
    } serial_state_t;

endpackage

// File: verilog/pin_sync3.sv
// Purpose: Three-flop synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: The output follows only when the second and third flops agree.
`timescale 1ns/1ns
module pin_sync3 #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    // ==================================================================
    // Per-bit chain
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic meta_ff;
            logic mid_ff;
            logic late_ff;
            logic out_ff;
            // Idle serial lines are high, so the chain resets high.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_ff <= 1'b1;
                    mid_ff <= 1'b1;
                    late_ff <= 1'b1;
                    out_ff <= 1'b1;
                end else begin
                    meta_ff <= d_i[g];
                    mid_ff <= meta_ff;
                    late_ff <= mid_ff;
                    if (mid_ff == late_ff) begin
                        out_ff <= late_ff;
                    end
                end
            end
            assign q_o[g] = out_ff;
        end
    endgenerate

endmodule

// File: verilog/control_and_write_lock_regs.sv
// Purpose: Serial-bus slave holding the control and write-unlock registers.
// Assumes: SCL below about 1 MHz so each bus phase spans many clk_i cycles.
// Notes: The application register lives outside; writes to it leave here
// as a pulse with the protected bits already gated.
// Contract
// - Control bit 4 picks regulator limit; reset 0 is 370mA, 1 is 270mA.
// - Control bits 1:0 hold a read-only maker code that writes never alter.
// - Writing key 4CH unlocks application bits 4:2; key then reads 01H.
// - Writing any other value locks application bits 4:2; key reads 00H.
// - After reset the key register reads 00H, so protected bits stay locked.
// - Registers use an 8-bit index that steps by one per written byte and per read byte that the host ACKs.
`timescale 1ns/1ns
module control_and_write_lock_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h3E,
    // The maker code value is arbitrary.
    parameter logic [1:0] VENDOR_ID = 2'h2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] app_cfg_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic regulator_limit_select_o,
    output logic write_unlocked_o,
    output logic app_wr_o,
    output logic [7:0] app_wdata_o
);

    // ==================================================================
    // Pin synchronisation and bus events
    logic [1:0] pins;
    logic scl;
    logic sda;
    logic scl_prev_ff;
    logic sda_prev_ff;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    pin_sync3 #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({scl_i, sda_i}),
        .q_o(pins)
    );
    assign scl = pins[1];
    assign sda = pins[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_prev_ff <= scl;
            sda_prev_ff <= sda;
        end
    end

    assign scl_rise = scl & ~scl_prev_ff;
    assign scl_fall = ~scl & scl_prev_ff;
    assign bus_start = scl & scl_prev_ff & sda_prev_ff & ~sda;
    assign bus_stop = scl & scl_prev_ff & ~sda_prev_ff & sda;

    // ==================================================================
    // Register state and read mux
    logic limit_ff;
    logic unlocked_ff;
    logic [7:0] ctrl_rd;
    logic [7:0] key_rd;
    logic [7:0] rd_data;
    logic [7:0] ptr_ff;
    bias_regs_pkg::reg_write_t wr_ff;
    assign ctrl_rd = {3'h0, limit_ff, 2'h0, VENDOR_ID};
    assign key_rd = unlocked_ff ? bias_regs_pkg::KEY_RD_OPEN
                                : bias_regs_pkg::KEY_RD_SHUT;
    always_comb begin
        case (ptr_ff)
            bias_regs_pkg::CTRL_ADDR: rd_data = ctrl_rd;
            bias_regs_pkg::KEY_ADDR: rd_data = key_rd;
            bias_regs_pkg::APPLICATION_CONFIG_ADDR: rd_data = app_cfg_i;
            default: rd_data = bias_regs_pkg::UNMAPPED_RD;
        endcase
    end

    // ==================================================================
    // Serial slave state machine
    bias_regs_pkg::serial_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] rx_ff;
    logic [7:0] tx_ff;
    logic rw_ff;
    logic mack_ff;
    logic oe_n_ff;
    logic byte_done;
    assign byte_done = bit_cnt_ff == bias_regs_pkg::BITS_PER_BYTE;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= bias_regs_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            rx_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            mack_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            wr_ff <= '0;
        end else begin
            wr_ff.valid <= 1'b0;
            if (bus_start) begin
                state_ff <= bias_regs_pkg::ST_ADDR;
                bit_cnt_ff <= 4'h0;
                oe_n_ff <= 1'b1;
            end else if (bus_stop) begin
                state_ff <= bias_regs_pkg::ST_IDLE;
                oe_n_ff <= 1'b1;
            end else if (scl_rise) begin
                if (state_ff == bias_regs_pkg::ST_ADDR ||
                    state_ff == bias_regs_pkg::ST_REG ||
                    state_ff == bias_regs_pkg::ST_WDATA) begin
                    rx_ff <= {rx_ff[6:0], sda};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end else if (state_ff == bias_regs_pkg::ST_MASTER_ACK) begin
                    // Stepping here lets the fall load the next byte.
                    mack_ff <= ~sda;
                    if (!sda) begin
                        ptr_ff <= ptr_ff + 8'h01;
                    end
                end
            end else if (scl_fall) begin
                unique case (state_ff)
                    bias_regs_pkg::ST_IDLE: begin
                        oe_n_ff <= 1'b1;
                    end
                    bias_regs_pkg::ST_ADDR: begin
                        if (byte_done) begin
                            if (rx_ff[7:1] == DEV_ADDR) begin
                                oe_n_ff <= 1'b0;
                                rw_ff <= rx_ff[0];
                                state_ff <= bias_regs_pkg::ST_ADDR_ACK;
                            end else begin
                                state_ff <= bias_regs_pkg::ST_IDLE;
                            end
                        end
                    end
                    bias_regs_pkg::ST_ADDR_ACK: begin
                        bit_cnt_ff <= 4'h0;
                        if (rw_ff) begin
                            oe_n_ff <= rd_data[7];
                            tx_ff <= {rd_data[6:0], 1'b0};
                            bit_cnt_ff <= 4'h1;
                            state_ff <= bias_regs_pkg::ST_RDATA;
                        end else begin
                            oe_n_ff <= 1'b1;
                            state_ff <= bias_regs_pkg::ST_REG;
                        end
                    end
                    bias_regs_pkg::ST_REG: begin
                        if (byte_done) begin
                            oe_n_ff <= 1'b0;
                            ptr_ff <= rx_ff;
                            state_ff <= bias_regs_pkg::ST_REG_ACK;
                        end
                    end
                    bias_regs_pkg::ST_REG_ACK,
                    bias_regs_pkg::ST_WDATA_ACK: begin
                        oe_n_ff <= 1'b1;
                        bit_cnt_ff <= 4'h0;
                        state_ff <= bias_regs_pkg::ST_WDATA;
                    end
                    bias_regs_pkg::ST_WDATA: begin
                        if (byte_done) begin
                            oe_n_ff <= 1'b0;
                            wr_ff <= {1'b1, ptr_ff, rx_ff};
                            ptr_ff <= ptr_ff + 8'h01;
                            state_ff <= bias_regs_pkg::ST_WDATA_ACK;
                        end
                    end
                    bias_regs_pkg::ST_RDATA: begin
                        if (byte_done) begin
                            oe_n_ff <= 1'b1;
                            state_ff <= bias_regs_pkg::ST_MASTER_ACK;
                        end else begin
                            oe_n_ff <= tx_ff[7];
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                    bias_regs_pkg::ST_MASTER_ACK: begin
                        if (mack_ff) begin
                            oe_n_ff <= rd_data[7];
                            tx_ff <= {rd_data[6:0], 1'b0};
                            bit_cnt_ff <= 4'h1;
                            state_ff <= bias_regs_pkg::ST_RDATA;
                        end else begin
                            state_ff <= bias_regs_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ==================================================================
    // Register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit_ff <= bias_regs_pkg::LIMIT_RST;
        end else if (wr_ff.valid &&
                     wr_ff.addr == bias_regs_pkg::CTRL_ADDR) begin
            // Only the limit bit is storage; the rest is fixed.
            limit_ff <= wr_ff.data[bias_regs_pkg::LIMIT_BIT];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlocked_ff <= bias_regs_pkg::UNLOCK_RST;
        end else if (wr_ff.valid &&
                     wr_ff.addr == bias_regs_pkg::KEY_ADDR) begin
            unlocked_ff <= wr_ff.data == bias_regs_pkg::UNLOCK_KEY;
        end
    end
    // While locked, the protected bits are written back unchanged, so a
    // host that skips the key cannot toggle either output enable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            app_wr_o <= 1'b0;
            app_wdata_o <= 8'h00;
        end else begin
            app_wr_o <= wr_ff.valid &&
                        wr_ff.addr == bias_regs_pkg::APPLICATION_CONFIG_ADDR;
            if (wr_ff.valid && wr_ff.addr == bias_regs_pkg::APPLICATION_CONFIG_ADDR) begin
                app_wdata_o <= unlocked_ff ? wr_ff.data :
                    (wr_ff.data & ~bias_regs_pkg::APPLICATION_CONFIG_LOCK_MASK) |
                    (app_cfg_i & bias_regs_pkg::APPLICATION_CONFIG_LOCK_MASK);
            end
        end
    end
    // Open drain: the level is always low, only the enable moves.
    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;
    end
    assign sda_oe_n_o = oe_n_ff;
    assign regulator_limit_select_o = limit_ff;
    assign write_unlocked_o = unlocked_ff;

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wr(logic [7:0] a);
        wr_ff.valid && wr_ff.addr == a;
    endsequence
    sequence s_key_ok;
        s_wr(bias_regs_pkg::KEY_ADDR) ##0
            wr_ff.data == bias_regs_pkg::UNLOCK_KEY;
    endsequence
    a_limit_follow: assert property (
        s_wr(bias_regs_pkg::CTRL_ADDR) |=>
            regulator_limit_select_o ==
            $past(wr_ff.data[bias_regs_pkg::LIMIT_BIT]))
        else $error("Limit select did not follow control write.");
    a_vendor_fixed: assert property (
        s_wr(bias_regs_pkg::CTRL_ADDR) |=> ctrl_rd[1:0] == VENDOR_ID)
        else $error("Maker code changed.");
    a_key_unlock: assert property (
        s_key_ok |=> write_unlocked_o &&
            key_rd == bias_regs_pkg::KEY_RD_OPEN)
        else $error("Key write did not unlock.");
    a_key_lock: assert property (
        s_wr(bias_regs_pkg::KEY_ADDR) ##0
            wr_ff.data != bias_regs_pkg::UNLOCK_KEY |=>
            !write_unlocked_o && key_rd == bias_regs_pkg::KEY_RD_SHUT)
        else $error("Wrong key did not lock.");
    a_locked_gate: assert property (
        s_wr(bias_regs_pkg::APPLICATION_CONFIG_ADDR) ##0 !unlocked_ff |=>
            app_wr_o && app_wdata_o[4:2] == $past(app_cfg_i[4:2]))
        else $error("Protected bits changed while locked.");
    a_unlocked_pass: assert property (
        s_wr(bias_regs_pkg::APPLICATION_CONFIG_ADDR) ##0 unlocked_ff |=>
            app_wr_o && app_wdata_o == $past(wr_ff.data))
        else $error("Unlocked write was altered.");
    a_reset_locked: assert property (
        $fell(rst_i) |-> key_rd == bias_regs_pkg::KEY_RD_SHUT &&
            !write_unlocked_o)
        else $error("Key register not clear after reset.");
    a_ptr_step: assert property (
        wr_ff.valid |-> ptr_ff == wr_ff.addr + 8'h01)
        else $error("Register index did not step after write.");
    a_rsvd_zero: assert property (
        ctrl_rd[7:5] == 3'h0 && ctrl_rd[3:2] == 2'h0)
        else $error("Reserved control bits not zero.");
endmodule

// File: bench/i2c_host_model.sv
// Purpose: Behavioural serial-bus host that reaches the register block.
// Assumes: The bus has a pull-up, so a released line reads high.
// Notes: Lines change only at rising clk_i edges, with SDA moved in the
// middle of the SCL low phase so no false START or STOP is ever seen.
`timescale 1ns/1ns
module i2c_host_model #(
    parameter int HALF = 10
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // ==================================================================
    // Bit level
    task automatic hold();
        repeat (HALF) @(posedge clk_i);
    endtask

    task automatic start();
        hold();
        sda_o <= 1'b1;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_o <= 1'b0;
        hold();
        scl_o <= 1'b0;
    endtask

    task automatic stop();
        hold();
        sda_o <= 1'b0;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_o <= 1'b1;
        hold();
    endtask

    task automatic bit_out(input logic b);
        hold();
        sda_o <= b;
        hold();
        scl_o <= 1'b1;
        hold();
        scl_o <= 1'b0;
    endtask

    task automatic bit_in(output logic b);
        hold();
        sda_o <= 1'b1;
        hold();
        scl_o <= 1'b1;
        hold();
        b = sda_i;
        scl_o <= 1'b0;
    endtask

    // ==================================================================
    // Byte and transfer level
    task automatic send(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(nack);
    endtask

    task automatic recv(input logic nack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(nack);
    endtask

    task automatic write_regs(input logic [6:0] dev, input logic [7:0] idx,
            input logic [7:0] d0, input logic [7:0] d1, input int n,
            output logic nack);
        logic a;
        start();
        send({dev, 1'b0}, nack);
        if (nack === 1'b0) begin
            send(idx, a);
            nack = a;
            send(d0, a);
            nack |= a;
            if (n > 1) send(d1, a);
            if (n > 1) nack |= a;
        end
        stop();
    endtask

    task automatic read_regs(input logic [6:0] dev, input logic [7:0] idx,
            input int n, output logic [23:0] q);
        logic a;
        logic [7:0] b;
        q = 24'h0;
        start();
        send({dev, 1'b0}, a);
        send(idx, a);
        start();
        send({dev, 1'b1}, a);
        for (int k = 0; k < n; k++) begin
            recv(k == n - 1, b);
            q[8*k +: 8] = b;
        end
        stop();
    endtask
endmodule

// File: bench/tb.sv
// Purpose: Self-checking bench for the control and write-unlock registers.
// Assumes: The application register is modelled here, reset to 8'h43.
// Notes: Every expectation is built from the bit layout, not from outputs.
`timescale 1ns/1ns
module tb;
    localparam logic [6:0] DEV = 7'h3E;
    // The maker code value is arbitrary.
    localparam logic [1:0] VID = 2'h2;
    localparam logic [7:0] APPLICATION_CONFIG = bias_regs_pkg::APPLICATION_CONFIG_ADDR;
    localparam logic [7:0] CTRL = bias_regs_pkg::CTRL_ADDR;
    localparam logic [7:0] KEY = bias_regs_pkg::KEY_ADDR;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic scl;
    logic host_sda;
    logic sda_wire;
    logic [7:0] app_cfg_ff = 8'h43;
    logic sda_o, sda_oe_n_o, limit, unl, app_wr, nack;
    logic [7:0] app_wdata;
    logic [23:0] q;
    int fail_count = 0;
    int tests_run = 0;
    logic [7:0] others [3] = '{8'h00, 8'h4D, 8'hCC};

    always #20 clk_i = ~clk_i;

    // Open-drain wire: either party pulling low wins over the pull-up.
    assign sda_wire = host_sda & (sda_oe_n_o ? 1'b1 : sda_o);

    // The application register lives outside the block under test.
    always @(posedge clk_i) begin
        if (rst_i) app_cfg_ff <= 8'h43;
        else if (app_wr) app_cfg_ff <= app_wdata;
    end

    i2c_host_model host (.clk_i(clk_i), .sda_i(sda_wire), .scl_o(scl),
        .sda_o(host_sda));

    control_and_write_lock_regs #(.DEV_ADDR(DEV), .VENDOR_ID(VID)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_wire),
        .app_cfg_i(app_cfg_ff), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .regulator_limit_select_o(limit), .write_unlocked_o(unl),
        .app_wr_o(app_wr), .app_wdata_o(app_wdata));

    // ==================================================================
    // Checking and closing
    task automatic check(input string name, input logic [7:0] seen,
            input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d0,
            input logic [7:0] d1, input int n);
        host.write_regs(DEV, idx, d0, d1, n, nack);
        check("write ack", {7'h0, nack}, 8'h00);
    endtask

    function automatic logic [7:0] ctrl_exp(input logic lim);
        return {3'h0, lim, 2'h0, VID};
    endfunction

    // ==================================================================
    // Sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        host.read_regs(DEV, CTRL, 1, q);
        check("ctrl reset", q[7:0], ctrl_exp(1'b0));
        check("limit reset", {7'h0, limit}, 8'h00);
        host.read_regs(DEV, KEY, 1, q);
        check("key reset", q[7:0], 8'h00);
        check("unlock reset", {7'h0, unl}, 8'h00);
        // Locked: bits 4:2 keep their old value, others pass.
        wr(APPLICATION_CONFIG, 8'h9C, 8'h00, 1);
        check("application_config locked", app_cfg_ff, 8'h80);
        host.read_regs(DEV, APPLICATION_CONFIG, 1, q);
        check("application_config readback", q[7:0], 8'h80);
        // The key goes in before the enable bits change.
        wr(KEY, 8'h4C, 8'h00, 1);
        host.read_regs(DEV, KEY, 1, q);
        check("key open", q[7:0], 8'h01);
        check("unlock open", {7'h0, unl}, 8'h01);
        wr(APPLICATION_CONFIG, 8'h18, 8'h00, 1);
        check("application_config unlocked", app_cfg_ff, 8'h18);
        for (int i = 0; i < 3; i++) begin
            wr(KEY, 8'h4C, 8'h00, 1);
            wr(KEY, others[i], 8'h00, 1);
            host.read_regs(DEV, KEY, 1, q);
            check("key shut", q[7:0], 8'h00);
            check("unlock shut", {7'h0, unl}, 8'h00);
        end
        wr(APPLICATION_CONFIG, 8'h04, 8'h00, 1);
        check("application_config relocked", app_cfg_ff, 8'h18);
        wr(CTRL, 8'hFF, 8'h00, 1);
        check("limit set", {7'h0, limit}, 8'h01);
        host.read_regs(DEV, CTRL, 1, q);
        check("ctrl ones", q[7:0], ctrl_exp(1'b1));
        wr(CTRL, 8'hED, 8'h00, 1);
        check("limit clear", {7'h0, limit}, 8'h00);
        host.read_regs(DEV, CTRL, 1, q);
        check("ctrl zeros", q[7:0], ctrl_exp(1'b0));
        // Burst write steps from the application index to control.
        wr(APPLICATION_CONFIG, 8'h00, 8'h10, 2);
        check("burst limit", {7'h0, limit}, 8'h01);
        host.read_regs(DEV, APPLICATION_CONFIG, 3, q);
        check("burst application_config", q[7:0], 8'h18);
        check("burst ctrl", q[15:8], ctrl_exp(1'b1));
        check("burst unmapped", q[23:16], 8'h00);
        host.write_regs(7'h3F, CTRL, 8'h00, 8'h00, 1, nack);
        check("foreign nack", {7'h0, nack}, 8'h01);
        check("foreign ignored", {7'h0, limit}, 8'h01);
        results();
    end

    initial begin
        repeat (90000) @(posedge clk_i);
        fail_count++;
        results();
    end
endmodule
